// >>> src/chgc_pkg.sv
// Package of constants and types for the charger control block
package chgc_pkg;

  // Clock and interrupt pulse timing
  localparam int unsigned CLK_FREQ_HZ     = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned INT_PULSE_US    = 128;
  localparam int unsigned INT_PULSE_CYC   = (INT_PULSE_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned INT_CNT_W       = 11;

  // Ship mode wake timing, in milliseconds
  localparam int unsigned WAKE_PRESS_MS   = 2000;
  localparam int unsigned WAKE_PRESS_CYC  = WAKE_PRESS_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned HW_RESET_MS     = 8000;
  localparam int unsigned HW_RESET_CYC    = HW_RESET_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned BTN_CNT_W       = 28;

  // Current settings in units of 0.5 mA
  localparam int unsigned CUR_W              = 10;
  localparam logic [9:0]  FAST_CHG_MAX       = 10'h3E8;
  localparam logic [9:0]  TERM_MIN           = 10'h001;
  localparam logic [9:0]  FAST_CHG_RESET     = 10'h014;
  localparam logic [9:0]  PRECHG_RESET       = 10'h005;
  localparam logic [9:0]  TERM_RESET         = 10'h002;
  localparam logic [9:0]  ILIM_RESET         = 10'h0C8;
  localparam logic [9:0]  PRECHG_TO_CC_MV    = 10'h3E8;

  // Regulator output in units of 100 mV
  localparam logic [5:0]  REG_OUT_RESET      = 6'h12;
  localparam logic        VIN_PM_RESET       = 1'b1;

  // Battery voltage threshold in 3 mV units of the sense input
  localparam int unsigned VBAT_W             = 12;
  localparam logic [11:0] VBAT_PRECHG_TH     = 12'h3E8;

  // Thermistor zones
  localparam int unsigned TS_W               = 8;
  localparam logic [7:0]  TS_HOT_RESET       = 8'h40;
  localparam logic [7:0]  TS_COLD_RESET      = 8'hC0;

  typedef enum logic [3:0] {
    CHGC_IDLE = 4'b0001,
    CHGC_PRE  = 4'b0010,
    CHGC_CC   = 4'b0100,
    CHGC_CV   = 4'b1000
  } chgc_phase_type;

  function automatic logic [9:0] chgc_clamp(input logic [9:0] val, input logic [9:0] lo, input logic [9:0] hi);
    chgc_clamp = (val < lo) ? lo : ((val > hi) ? hi : val);
  endfunction : chgc_clamp

endpackage : chgc_pkg

// >>> src/chgc_irq_if.sv
// Interface between the control core and the interrupt pulse generator
`timescale 1ns/100ps
interface chgc_irq_if;
  logic fault_evt;
  logic mask;
  logic busy;
  modport core (output fault_evt, output mask, input busy);
  modport pulse (input fault_evt, input mask, output busy);
endinterface : chgc_irq_if

// >>> src/chgc_int_pulse.sv
// Fixed width open-drain interrupt pulse generator
`timescale 1ns/100ps
module chgc_int_pulse
  import chgc_pkg::*;
(
  // Clock and reset
  input  wire logic  i_mclk,
  input  wire logic  i_rst_sync_b,
  // Core side
  chgc_irq_if.pulse  irq,
  // Pin drive
  output logic       o_int_oe
);

  logic [INT_CNT_W-1:0] cnt;
  logic [INT_CNT_W-1:0] next_cnt;
  logic                 next_oe;

  // R6 R7 R18 Pulse timing
  always_comb begin
    next_cnt = cnt;
    next_oe  = o_int_oe;
    if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
      next_oe  = (cnt != INT_CNT_W'(1));
    end else if (irq.fault_evt && !irq.mask) begin
      next_cnt = INT_CNT_W'(INT_PULSE_CYC);
      next_oe  = 1'b1;
    end else begin
      next_oe  = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_sync_b) begin
    if (!i_rst_sync_b) begin
      cnt      <= '0;
      o_int_oe <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      o_int_oe <= next_oe;
    end
  end

  assign irq.busy = o_int_oe;

  // R6 Pulse width
  chk_int_pulse_width: assert property (@(posedge i_mclk) disable iff (!i_rst_sync_b) // R6
    $rose(o_int_oe) |-> (cnt > INT_CNT_W'(1000)) ##1 o_int_oe [*8])
    else $error("interrupt pulse too short");
  // R7 Masked stays released
  chk_int_mask_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_sync_b) // R7
    (irq.mask && !o_int_oe) |=> !o_int_oe)
    else $error("interrupt fired while masked");
  // R18 Release on count end
  chk_int_release: assert property (@(posedge i_mclk) disable iff (!i_rst_sync_b) // R18
    (cnt == INT_CNT_W'(1)) |=> !o_int_oe)
    else $error("interrupt not released");
  cov_int_pulse: cover property (@(posedge i_mclk) disable iff (!i_rst_sync_b) $fell(o_int_oe));

endmodule : chgc_int_pulse

// >>> src/chgc_core.sv
// Charger control core: pins gating, phases, power path, defaults, wake
// Operation
// R1: With supply valid, charge-disable low or open enables charge, high disables.
// R2: Charge-disable pin is ignored whenever the input supply is absent.
// R3: On battery only, low-power select held low enters low power mode.
// R4: Host drives low-power select high before serial traffic when supply absent.
// R5: Low-power select is ignored while the input supply is present.
// R6: Each fault drives the interrupt pin low for one 128 us pulse; a fault during an active pulse starts no pulse of its own.
// R7: Interrupt pulses only when unmasked; pin stays released when masked.
// R8: Charging runs pre-charge, then constant current, then constant voltage.
// R9: Charge current programmable to 500 mA, termination down to 0.5 mA.
// R10: Host may disconnect adapter, battery or both from the power path.
// R11: Thermistor sense alters charge parameters using host-set thresholds.
// R12: Input limit, charge current and regulator voltage are host configurable.
// R13: Auxiliary regulator is controlled independently of the charger.
// R14: Reset defaults: fast 10 mA, pre-charge 2.5 mA, termination one tenth.
// R15: Reset defaults: input limit 100 mA, power management on, regulator 1.8 V.
// R16: Reset default wake press time is two seconds.
// R17: Wake press leaves ship mode; longer hold triggers hardware reset.
// R18: Pulse timed by counter; open-drain pin released when no pulse active.
`timescale 1ns/100ps
module chgc_core
  import chgc_pkg::*;
#(
  parameter int unsigned WAKE_CYC  = WAKE_PRESS_CYC,
  parameter int unsigned HWRST_CYC = HW_RESET_CYC
) (
  // Clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst_b,
  // Device pins
  input  wire logic              i_input_supply,
  input  wire logic              i_charge_disable,
  input  wire logic              i_low_power_select_n,
  input  wire logic              i_push_button_n,
  output logic                   o_int_out,
  output logic                   o_int_oe,
  // Analog status
  input  wire logic [VBAT_W-1:0] i_vbat,
  input  wire logic              i_cv_reached,
  input  wire logic [CUR_W-1:0]  i_ichg_meas,
  input  wire logic [TS_W-1:0]   i_thermistor_sense,
  input  wire logic              i_fault,
  // Host configuration
  input  wire logic              i_cfg_load,
  input  wire logic [CUR_W-1:0]  i_cfg_fast_charge_current,
  input  wire logic [CUR_W-1:0]  i_cfg_precharge_current,
  input  wire logic [CUR_W-1:0]  i_cfg_termination_current,
  input  wire logic [CUR_W-1:0]  i_cfg_input_current_limit,
  input  wire logic [5:0]        i_cfg_regulator_output_voltage,
  input  wire logic              i_cfg_input_voltage_power_mgmt,
  input  wire logic              i_cfg_regulator_en,
  input  wire logic              i_cfg_int_mask,
  input  wire logic              i_cfg_disc_adapter,
  input  wire logic              i_cfg_disc_battery,
  input  wire logic [TS_W-1:0]   i_cfg_ts_hot,
  input  wire logic [TS_W-1:0]   i_cfg_ts_cold,
  input  wire logic              i_ship_enter,
  // Status and control outputs
  output logic                   o_charge_en,
  output logic                   o_low_power,
  output logic                   o_serial_allowed,
  output logic [3:0]             o_phase,
  output logic [CUR_W-1:0]       o_ichg_target,
  output logic [CUR_W-1:0]       o_input_current_limit,
  output logic [5:0]             o_regulator_output_voltage,
  output logic                   o_input_voltage_power_mgmt,
  output logic                   o_regulator_en,
  output logic                   o_adapter_conn,
  output logic                   o_battery_conn,
  output logic                   o_ship_mode,
  output logic                   o_hw_reset
);

  logic [1:0] rst_sync;
  logic       rst_b;
  logic [2:0] s_vin, s_ce, s_lp, s_mr;
  logic       input_supply, ce, lp_n, mr_n;
  logic       next_vin, next_ce, next_lp, next_mr;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_b = rst_sync[1];

  // Pin filter: second and third flops must agree
  always_comb begin
    next_vin = (s_vin[1] == s_vin[2]) ? s_vin[2] : input_supply;
    next_ce  = (s_ce[1]  == s_ce[2])  ? s_ce[2]  : ce;
    next_lp  = (s_lp[1]  == s_lp[2])  ? s_lp[2]  : lp_n;
    next_mr  = (s_mr[1]  == s_mr[2])  ? s_mr[2]  : mr_n;
  end

  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_vin <= 3'h0;
      s_ce  <= 3'h0;
      s_lp  <= 3'h0;
      s_mr  <= 3'h7;
      input_supply   <= 1'b0;
      ce    <= 1'b0;
      lp_n  <= 1'b0;
      mr_n  <= 1'b1;
    end else begin
      s_vin <= {s_vin[1:0], i_input_supply};
      s_ce  <= {s_ce[1:0], i_charge_disable};
      s_lp  <= {s_lp[1:0], i_low_power_select_n};
      s_mr  <= {s_mr[1:0], i_push_button_n};
      input_supply   <= next_vin;
      ce    <= next_ce;
      lp_n  <= next_lp;
      mr_n  <= next_mr;
    end
  end

  // Configuration registers
  logic [CUR_W-1:0] fast, pre, term, ilim;
  logic [5:0]       vreg;
  logic             vpm, reg_en, mask, disc_a, disc_b;
  logic [TS_W-1:0]  ts_hot, ts_cold;
  logic [CUR_W-1:0] next_fast, next_pre, next_term, next_ilim;
  logic [5:0]       next_vreg;
  logic             next_vpm, next_reg_en, next_mask, next_disc_a, next_disc_b;
  logic [TS_W-1:0]  next_ts_hot, next_ts_cold;

  // R9 R12 R13 R10 R11 Host settings
  always_comb begin
    next_fast    = fast;
    next_pre     = pre;
    next_term    = term;
    next_ilim    = ilim;
    next_vreg    = vreg;
    next_vpm     = vpm;
    next_reg_en  = reg_en;
    next_mask    = mask;
    next_disc_a  = disc_a;
    next_disc_b  = disc_b;
    next_ts_hot  = ts_hot;
    next_ts_cold = ts_cold;
    if (i_cfg_load) begin
      next_fast    = chgc_clamp(i_cfg_fast_charge_current, TERM_MIN, FAST_CHG_MAX);
      next_pre     = chgc_clamp(i_cfg_precharge_current, TERM_MIN, FAST_CHG_MAX);
      next_term    = chgc_clamp(i_cfg_termination_current, TERM_MIN, FAST_CHG_MAX);
      next_ilim    = i_cfg_input_current_limit;
      next_vreg    = i_cfg_regulator_output_voltage;
      next_vpm     = i_cfg_input_voltage_power_mgmt;
      next_reg_en  = i_cfg_regulator_en;
      next_mask    = i_cfg_int_mask;
      next_disc_a  = i_cfg_disc_adapter;
      next_disc_b  = i_cfg_disc_battery;
      next_ts_hot  = i_cfg_ts_hot;
      next_ts_cold = i_cfg_ts_cold;
    end
  end

  // R14 R15 Reset defaults
  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      fast    <= FAST_CHG_RESET;
      pre     <= PRECHG_RESET;
      term    <= TERM_RESET;
      ilim    <= ILIM_RESET;
      vreg    <= REG_OUT_RESET;
      vpm     <= VIN_PM_RESET;
      reg_en  <= 1'b0;
      mask    <= 1'b0;
      disc_a  <= 1'b0;
      disc_b  <= 1'b0;
      ts_hot  <= TS_HOT_RESET;
      ts_cold <= TS_COLD_RESET;
    end else begin
      fast    <= next_fast;
      pre     <= next_pre;
      term    <= next_term;
      ilim    <= next_ilim;
      vreg    <= next_vreg;
      vpm     <= next_vpm;
      reg_en  <= next_reg_en;
      mask    <= next_mask;
      disc_a  <= next_disc_a;
      disc_b  <= next_disc_b;
      ts_hot  <= next_ts_hot;
      ts_cold <= next_ts_cold;
    end
  end

  // Charge sequencing
  chgc_phase_type   phase, next_phase;
  logic             chg_ok, ts_ok, ts_warm;
  logic             next_chg_en, next_lp_mode, next_ser;
  logic [CUR_W-1:0] next_target;

  // R1 R2 Charge enable gating
  assign chg_ok = input_supply && !ce && !disc_a && !disc_b;
  // R11 Thermistor window; halve fast charge current near hot limit
  assign ts_ok   = (i_thermistor_sense > ts_hot) && (i_thermistor_sense < ts_cold);
  assign ts_warm = (i_thermistor_sense < (ts_hot + TS_W'(16)));

  // R8 Three phase order
  always_comb begin
    next_phase = phase;
    unique case (phase)
      CHGC_IDLE: if (chg_ok && ts_ok) next_phase = CHGC_PRE;
      CHGC_PRE:  if (!chg_ok || !ts_ok) next_phase = CHGC_IDLE;
                 else if (i_vbat >= VBAT_PRECHG_TH) next_phase = CHGC_CC;
      CHGC_CC:   if (!chg_ok || !ts_ok) next_phase = CHGC_IDLE;
                 else if (i_cv_reached) next_phase = CHGC_CV;
      CHGC_CV:   if (!chg_ok || !ts_ok || (i_ichg_meas < term)) next_phase = CHGC_IDLE;
    endcase
  end

  always_comb begin
    unique case (phase)
      CHGC_PRE: next_target = pre;
      CHGC_CC,
      CHGC_CV:  next_target = ts_warm ? (fast >> 1) : fast;
      default:  next_target = '0;
    endcase
    // R3 R5 Low power select
    next_lp_mode = !input_supply && !lp_n;
    // R4 Serial with supply present or select high
    next_ser     = input_supply || lp_n;
    next_chg_en  = chg_ok;
  end

  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      phase            <= CHGC_IDLE;
      o_ichg_target    <= '0;
      o_charge_en      <= 1'b0;
      o_low_power      <= 1'b0;
      o_serial_allowed <= 1'b0;
    end else begin
      phase            <= next_phase;
      o_ichg_target    <= next_target;
      o_charge_en      <= next_chg_en;
      o_low_power      <= next_lp_mode;
      o_serial_allowed <= next_ser;
    end
  end

  // Registered copies of settings
  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      o_phase                    <= 4'h1;
      o_input_current_limit      <= ILIM_RESET;
      o_regulator_output_voltage <= REG_OUT_RESET;
      o_input_voltage_power_mgmt <= VIN_PM_RESET;
      o_regulator_en             <= 1'b0;
      o_adapter_conn             <= 1'b1;
      o_battery_conn             <= 1'b1;
    end else begin
      o_phase                    <= next_phase;
      o_input_current_limit      <= ilim;
      o_regulator_output_voltage <= vreg;
      o_input_voltage_power_mgmt <= vpm;
      o_regulator_en             <= reg_en;
      // R10 Power path disconnect
      o_adapter_conn             <= !disc_a;
      o_battery_conn             <= !disc_b;
    end
  end

  // Ship mode and push button timing; long count stays in hardware
  logic [BTN_CNT_W-1:0] btn, next_btn;
  logic                 next_ship, next_hwrst;

  // R16 R17 Wake and hardware reset
  always_comb begin
    next_btn   = mr_n ? '0 : ((btn == BTN_CNT_W'(HWRST_CYC)) ? btn : btn + 1'b1);
    next_ship  = o_ship_mode;
    if (i_ship_enter && !input_supply) next_ship = 1'b1;
    else if (input_supply || (btn >= BTN_CNT_W'(WAKE_CYC))) next_ship = 1'b0;
    next_hwrst = (btn == BTN_CNT_W'(HWRST_CYC - 1));
  end

  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      btn         <= '0;
      o_ship_mode <= 1'b0;
      o_hw_reset  <= 1'b0;
    end else begin
      btn         <= next_btn;
      o_ship_mode <= next_ship;
      o_hw_reset  <= next_hwrst;
    end
  end

  // R6 R7 Fault pulse generator
  chgc_irq_if irq ();
  assign irq.fault_evt = i_fault;
  assign irq.mask      = mask;
  chgc_int_pulse u_pulse (
    .i_mclk       (i_mclk),
    .i_rst_sync_b (rst_b),
    .irq          (irq),
    .o_int_oe     (o_int_oe)
  );
  assign o_int_out = 1'b0;

  chk_ce_gate: assert property (@(posedge i_mclk) disable iff (!rst_b) // R1
    (!input_supply || ce) |=> !o_charge_en)
    else $error("charge enabled while disabled");
  chk_ce_ignored: assert property (@(posedge i_mclk) disable iff (!rst_b) // R2
    (!input_supply && phase == CHGC_IDLE) |=> phase == CHGC_IDLE)
    else $error("charge started without supply");
  chk_lp_entry: assert property (@(posedge i_mclk) disable iff (!rst_b) // R3
    (!input_supply && !lp_n) |=> o_low_power && !o_serial_allowed)
    else $error("low power not entered");
  chk_lp_ignored: assert property (@(posedge i_mclk) disable iff (!rst_b) // R5
    input_supply |=> !o_low_power)
    else $error("low power with supply");
  chk_phase_order: assert property (@(posedge i_mclk) disable iff (!rst_b) // R8
    (phase == CHGC_IDLE) |=> (phase == CHGC_IDLE || phase == CHGC_PRE))
    else $error("phase skipped");
  chk_fast_max: assert property (@(posedge i_mclk) disable iff (!rst_b) // R9
    fast <= FAST_CHG_MAX && term >= TERM_MIN)
    else $error("current out of range");
  chk_disc_path: assert property (@(posedge i_mclk) disable iff (!rst_b) // R10
    disc_b |=> !o_battery_conn ##0 (phase == CHGC_IDLE))
    else $error("battery not disconnected");
  chk_ts_stop: assert property (@(posedge i_mclk) disable iff (!rst_b) // R11
    (!ts_ok && phase != CHGC_IDLE) |=> phase == CHGC_IDLE)
    else $error("charge outside thermal window");
  chk_wake: assert property (@(posedge i_mclk) disable iff (!rst_b) // R17
    (o_ship_mode && !i_ship_enter && btn >= BTN_CNT_W'(WAKE_CYC)) |=> !o_ship_mode)
    else $error("wake missed");
  cov_cv: cover property (@(posedge i_mclk) disable iff (!rst_b) phase == CHGC_CV);
  cov_lp: cover property (@(posedge i_mclk) disable iff (!rst_b) $rose(o_low_power));
  cov_wake: cover property (@(posedge i_mclk) disable iff (!rst_b) $fell(o_ship_mode));
  cov_hwrst: cover property (@(posedge i_mclk) disable iff (!rst_b) o_hw_reset);

endmodule : chgc_core

// >>> testbench/chgc_host_model.sv
// Host side model: open-drain interrupt line and low-power select drive
`timescale 1ns/100ps
module chgc_host_model (
  // Clock
  input  wire logic i_mclk,
  // Interrupt pin drive from the device
  input  wire logic i_int_oe,
  input  wire logic i_int_out,
  // Host intent
  input  wire logic i_sleep,
  // Pin drive and pulse record
  output logic      o_low_power_select_n,
  output int        o_pulse_cnt,
  output int        o_pulse_len
);
  logic int_line;
  int   run;

  // pull-up holds the line when released
  assign int_line = i_int_oe ? i_int_out : 1'b1;
  // select driven high unless sleep wanted
  assign o_low_power_select_n = ~i_sleep;

  initial begin
    o_pulse_cnt = 0;
    o_pulse_len = 0;
    run = 0;
  end

  // Low time measured in whole clock cycles
  always @(posedge i_mclk) begin
    if (int_line === 1'b0) begin
      run = run + 1;
    end else if (run != 0) begin
      o_pulse_len = run;
      o_pulse_cnt = o_pulse_cnt + 1;
      run = 0;
    end
  end
endmodule : chgc_host_model

// >>> testbench/charger_control_pins_irq_test.sv
// Self-checking bench of the charger control core
`timescale 1ns/100ps
module charger_control_pins_irq_test;
  import chgc_pkg::*;
  logic i_mclk, i_rst_b, sup, dis, lp_n, btn, cv, flt, ld, ship_in, sleep;
  logic [11:0] vbat;
  logic [9:0] meas, fast, pre, term, ilim;
  logic [7:0] ts, ts_hi, ts_lo;
  logic [5:0] vreg;
  logic vpm, reg_en, mask, d_ad, d_bat;
  logic int_out, int_oe, chg_en, low_pw, ser, hw_rst, ad_c, bat_c, ship_o, vpm_o, reg_o;
  logic [3:0] phase;
  logic [9:0] tgt, ilim_o;
  logic [5:0] vreg_o;
  int num_errors, samples_checked, pcnt, plen, hw_cnt, c0;

  chgc_core #(.WAKE_CYC(20), .HWRST_CYC(50)) dut (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_input_supply(sup), .i_charge_disable(dis),
    .i_low_power_select_n(lp_n), .i_push_button_n(btn), .o_int_out(int_out), .o_int_oe(int_oe),
    .i_vbat(vbat), .i_cv_reached(cv), .i_ichg_meas(meas), .i_thermistor_sense(ts), .i_fault(flt),
    .i_cfg_load(ld), .i_cfg_fast_charge_current(fast), .i_cfg_precharge_current(pre),
    .i_cfg_termination_current(term), .i_cfg_input_current_limit(ilim),
    .i_cfg_regulator_output_voltage(vreg), .i_cfg_input_voltage_power_mgmt(vpm),
    .i_cfg_regulator_en(reg_en), .i_cfg_int_mask(mask), .i_cfg_disc_adapter(d_ad),
    .i_cfg_disc_battery(d_bat), .i_cfg_ts_hot(ts_hi), .i_cfg_ts_cold(ts_lo), .i_ship_enter(ship_in),
    .o_charge_en(chg_en), .o_low_power(low_pw), .o_serial_allowed(ser), .o_phase(phase),
    .o_ichg_target(tgt), .o_input_current_limit(ilim_o), .o_regulator_output_voltage(vreg_o),
    .o_input_voltage_power_mgmt(vpm_o), .o_regulator_en(reg_o), .o_adapter_conn(ad_c),
    .o_battery_conn(bat_c), .o_ship_mode(ship_o), .o_hw_reset(hw_rst));

  chgc_host_model host (.i_mclk(i_mclk), .i_int_oe(int_oe), .i_int_out(int_out), .i_sleep(sleep),
    .o_low_power_select_n(lp_n), .o_pulse_cnt(pcnt), .o_pulse_len(plen));

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    if (hw_rst === 1'b1) hw_cnt = hw_cnt + 1;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : tick

  // Config is taken in one cycle and shows two cycles later
  task automatic load();
    ld = 1'b1;
    tick(1);
    ld = 1'b0;
    tick(4);
  endtask : load

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic t_reset();
    chk("ilim", ilim_o, ILIM_RESET);
    chk("vreg", vreg_o, REG_OUT_RESET);
    chk("vpm", vpm_o, VIN_PM_RESET);
    chk("int_oe", int_oe, 1'b0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_phases();
    tick(10);
    chk("phase pre", phase, CHGC_PRE);
    chk("pre cur", tgt, PRECHG_RESET);
    vbat = 12'h3E8;
    tick(10);
    chk("phase cc", phase, CHGC_CC);
    chk("fast cur", tgt, FAST_CHG_RESET);
    fast = 10'h3FF;
    reg_en = 1'b1;
    load();
    chk("fast max", tgt, 10'h3E8);
    chk("reg en", reg_o, 1'b1);
    chk("chg with reg", chg_en, 1'b1);
    ts = 8'h4F;
    tick(10);
    chk("warm cur", tgt, 10'h1F4);
    ts = 8'h40;
    tick(10);
    chk("hot stop", phase, CHGC_IDLE);
    chk("hot cur", tgt, 10'h000);
    ts_hi = 8'h30;
    load();
    tick(10);
    chk("hot moved", phase, CHGC_CC);
    ts = 8'h80;
    cv = 1'b1;
    meas = 10'h002;
    tick(10);
    chk("phase cv", phase, CHGC_CV);
    $display("test phases done");
  endtask : t_phases

  task automatic t_config();
    ilim = 10'h3E8;
    vreg = 6'h25;
    vpm = 1'b0;
    load();
    chk("ilim", ilim_o, 10'h3E8);
    chk("vreg", vreg_o, 6'h25);
    chk("vpm", vpm_o, 1'b0);
    d_ad = 1'b1;
    load();
    chk("adapter off", ad_c, 1'b0);
    chk("chg no adapter", chg_en, 1'b0);
    d_ad = 1'b0;
    d_bat = 1'b1;
    load();
    chk("battery off", bat_c, 1'b0);
    chk("adapter back", ad_c, 1'b1);
    d_bat = 1'b0;
    load();
    $display("test config done");
  endtask : t_config

  task automatic t_pins();
    dis = 1'b1;
    tick(10);
    chk("chg disabled", chg_en, 1'b0);
    dis = 1'b0;
    sleep = 1'b1;
    tick(10);
    chk("chg enabled", chg_en, 1'b1);
    chk("lp ignored", low_pw, 1'b0);
    sup = 1'b0;
    dis = 1'b1;
    tick(10);
    chk("low power", low_pw, 1'b1);
    chk("no serial", ser, 1'b0);
    dis = 1'b0;
    tick(10);
    chk("dis ignored", low_pw, 1'b1);
    chk("dis no charge", chg_en, 1'b0);
    sleep = 1'b0;
    tick(10);
    chk("awake", low_pw, 1'b0);
    chk("serial ok", ser, 1'b1);
    $display("test pins done");
  endtask : t_pins

  task automatic fault_wait(input int want);
    flt = 1'b1;
    tick(1);
    flt = 1'b0;
    for (int i = 0; i < 1400 && pcnt < want; i++) tick(1);
    if (pcnt < want) begin
      num_errors++;
      close_out();
    end
  endtask : fault_wait

  task automatic t_irq();
    c0 = pcnt;
    flt = 1'b1;
    tick(1);
    flt = 1'b0;
    tick(600);
    chk("pin low", int_oe, 1'b1);
    fault_wait(c0 + 1);
    tick(20);
    chk("one pulse", pcnt, c0 + 1);
    chk("pulse len", plen, INT_PULSE_CYC);
    mask = 1'b1;
    load();
    flt = 1'b1;
    tick(1);
    chk("masked pin", int_oe, 1'b0);
    flt = 1'b0;
    tick(1400);
    chk("masked", pcnt, c0 + 1);
    chk("released", int_oe, 1'b0);
    $display("test irq done");
  endtask : t_irq

  task automatic t_ship();
    sup = 1'b0;
    tick(10);
    ship_in = 1'b1;
    tick(1);
    ship_in = 1'b0;
    tick(8);
    chk("ship in", ship_o, 1'b1);
    btn = 1'b0;
    tick(35);
    chk("woken", ship_o, 1'b0);
    chk("no hw reset", hw_cnt, 0);
    tick(40);
    btn = 1'b1;
    tick(5);
    chk("hw reset", hw_cnt, 1);
    $display("test ship done");
  endtask : t_ship

  initial begin
    {sup, dis, cv, flt, ld, ship_in, sleep, vpm, reg_en, mask, d_ad, d_bat} = '0;
    i_rst_b = 1'b0;
    btn = 1'b1;
    vbat = 12'h100;
    meas = 10'h3FF;
    ts = 8'h80;
    ts_hi = TS_HOT_RESET;
    ts_lo = TS_COLD_RESET;
    fast = FAST_CHG_RESET;
    pre = PRECHG_RESET;
    term = TERM_RESET;
    ilim = ILIM_RESET;
    vreg = REG_OUT_RESET;
    num_errors = 0;
    samples_checked = 0;
    hw_cnt = 0;
    tick(10);
    i_rst_b = 1'b1;
    tick(4);
    t_reset();
    sup = 1'b1;
    t_phases();
    t_config();
    t_pins();
    sup = 1'b1;
    t_irq();
    t_ship();
    close_out();
  end

  initial begin
    repeat (100000) @(posedge i_mclk);
    num_errors++;
    close_out();
  end
endmodule : charger_control_pins_irq_test
